// *** rtl/address_error_and_interrupt_accept.sv ***
// Address error detection, interrupt ranking and exception entry sequencer.
//
// Summary of operation
// - Odd instruction fetch address raises address error.
// - Fetch inside peripheral space raises address error.
// - Word data access at odd address errors.
// - Longword access off four-byte boundary errors.
// - Address error entry waits for bus cycle and instructions.
// - Address error pushes status word, then PC.
// - Address error reads its vector, non-delayed jump.
// - Accept thirty-one on-chip peripheral request lines.
// - Accept NMI, user break, eight pins.
// - Each source owns a distinct vector number.
// - Highest ranked pending request starts handling.
// - Priority levels run zero to sixteen.
// - NMI is level sixteen, never masked.
// - User break fixed at level fifteen.
// - Pins and peripherals programmable zero to fifteen.
// - Others accepted only above the mask level.
// - Interrupt entry loads level into mask as stacking starts.
// - NMI entry writes fifteen into the mask.
// - Interrupt entry fetches vector and jumps there.
// - Nothing accepted while decoding a delay slot.
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps

module address_error_and_interrupt_accept
  import exc_pkg::*;
#(
  parameter logic [31:0] PERIPH_START = PERIPH_LO,
  parameter logic [31:0] PERIPH_END   = PERIPH_HI
) (
  input  wire logic                  clk_i,
  input  wire logic                  arst_n_i,
  input  wire apb_req_type           apb_i,
  output apb_rsp_type                apb_o,
  input  wire logic                  nmi_pin_i,
  input  wire logic [NUM_IRQ-1:0]    irq_pin_n_i,
  input  wire logic                  user_break_i,
  input  wire logic [NUM_PERIPH-1:0] periph_req_i,
  input  wire access_type            access_i,
  input  wire cpu_view_type          cpu_i,
  output cpu_load_type               cpu_load_o,
  output logic                       cpu_hold_o,
  output mem_req_type                mem_o,
  input  wire logic                  mem_ack_i,
  input  wire logic [31:0]           mem_rdata_i
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PUSH_SR,
    ST_PUSH_PC,
    ST_READ_VEC,
    ST_JUMP
  } state_type;

  typedef struct packed {
    state_type                             state;
    logic                                  nmi_meta;
    logic                                  nmi_sync;
    logic                                  nmi_prev;
    logic [NUM_IRQ-1:0]                    irq_meta_n;
    logic [NUM_IRQ-1:0]                    irq_sync_n;
    logic                                  nmi_pend;
    logic                                  aerr_pend;
    logic                                  aerr_dma;
    logic [NUM_PRIO_REGS-1:0][15:0]        prio;
    logic [7:0]                            vec;
    logic [7:0]                            last_vec;
    logic [31:0]                           saved_sr;
    logic [31:0]                           saved_pc;
    logic [31:0]                           sp;
    logic [31:0]                           vbr;
    mem_req_type                           mem;
    cpu_load_type                          load;
    apb_rsp_type                           rsp;
  } regs_type;

  regs_type state_reg;
  regs_type state_next;

  // Maps a peripheral source index onto its priority field.
  function automatic int periph_field(input int idx);
    if (idx < TMR_BASE) begin
      return FLD_DMA + (idx - DMA_BASE) / DMA_PER_FLD;
    end else if (idx < SER_BASE) begin
      return FLD_TMR + (idx - TMR_BASE) / TMR_PER_FLD;
    end else if (idx < ADC_BASE) begin
      return FLD_SER + (idx - SER_BASE) / SER_PER_FLD;
    end else begin
      return FLD_MISC;
    end
  endfunction

  // Reads one four-bit priority field out of the register array.
  function automatic logic [3:0] field_of(input logic [NUM_PRIO_REGS-1:0][15:0] p,
                                          input int fld);
    logic [15:0] word;
    word = p[fld / FIELDS_PER_REG];
    return word[(fld % FIELDS_PER_REG) * FIELD_W +: FIELD_W];
  endfunction

  // Ranking of all pending sources.
  logic       win_valid;
  logic [4:0] win_level;
  logic [7:0] win_vec;
  logic       win_nmi;
  logic [3:0] cur_mask;
  logic [3:0] lvl;
  logic       aerr_now;
  logic       aerr_now_dma;
  logic       mis_word;
  logic       mis_long;
  logic       fetch_bad;

  always_comb begin
    cur_mask  = cpu_i.status_word[MASK_MSB:MASK_LSB];
    win_valid = 1'b0;
    win_level = 5'h00;
    win_vec   = 8'h00;
    win_nmi   = 1'b0;
    lvl       = 4'h0;
    // Ties go to the lower source index because only a strictly higher level replaces.
    if (state_reg.nmi_pend) begin
      win_valid = 1'b1;
      win_level = LEVEL_NMI;
      win_vec   = VEC_NMI;
      win_nmi   = 1'b1;
    end
    if (user_break_i && (LEVEL_UBRK > {1'b0, cur_mask}) && (LEVEL_UBRK > win_level)) begin
      win_valid = 1'b1;
      win_level = LEVEL_UBRK;
      win_vec   = VEC_UBRK;
    end
    for (int i = 0; i < NUM_IRQ; i++) begin
      lvl = field_of(state_reg.prio, FLD_IRQ + i);
      if (!state_reg.irq_sync_n[i] && (lvl > cur_mask) && ({1'b0, lvl} > win_level)) begin
        win_valid = 1'b1;
        win_level = {1'b0, lvl};
        win_vec   = VEC_IRQ_BASE + 8'(i);
      end
    end
    for (int i = 0; i < NUM_PERIPH; i++) begin
      lvl = field_of(state_reg.prio, periph_field(i));
      if (periph_req_i[i] && (lvl > cur_mask) && ({1'b0, lvl} > win_level)) begin
        win_valid = 1'b1;
        win_level = {1'b0, lvl};
        win_vec   = VEC_PER_BASE + 8'(i);
      end
    end
  end

  // Alignment and space checks on the access being presented this cycle.
  always_comb begin
    fetch_bad    = access_i.is_fetch && (access_i.addr[0]
                 || ((access_i.addr >= PERIPH_START) && (access_i.addr <= PERIPH_END)));
    mis_word     = !access_i.is_fetch && (access_i.size == SIZE_WORD)
                 && access_i.addr[0];
    mis_long     = !access_i.is_fetch && (access_i.size == SIZE_LONG)
                 && (access_i.addr[1:0] != 2'b00);
    aerr_now     = access_i.valid && (fetch_bad || mis_word || mis_long);
    aerr_now_dma = access_i.is_dma && !access_i.is_fetch;
  end

  // Register access decode.
  logic        apb_acc;
  logic [31:0] rd_data;
  logic        rd_err;
  logic [2:0]  prio_idx;

  always_comb begin
    apb_acc  = apb_i.psel && apb_i.penable;
    rd_data  = 32'h0000_0000;
    rd_err   = 1'b0;
    prio_idx = apb_i.paddr[4:2];
    if ((apb_i.paddr >= ADDR_PRIO_A) && (apb_i.paddr <= ADDR_PRIO_E)
        && (apb_i.paddr[1:0] == 2'b00)) begin
      rd_data = {16'h0000, state_reg.prio[prio_idx]};
    end else if (apb_i.paddr == ADDR_STATUS) begin
      rd_data = {20'h00000, state_reg.last_vec, 1'b0, 3'(state_reg.state)};
    end else if (apb_i.paddr == ADDR_PEND) begin
      rd_data = {16'h0000, win_level[3:0], 1'b0, win_valid,
                 state_reg.aerr_dma, state_reg.aerr_pend, win_vec};
    end else begin
      rd_err = 1'b1;
    end
  end

  logic accept_ok;
  logic aerr_go;
  logic int_go;

  always_comb begin
    state_next = state_reg;

    state_next.nmi_meta   = nmi_pin_i;
    state_next.nmi_sync   = state_reg.nmi_meta;
    state_next.nmi_prev   = state_reg.nmi_sync;
    state_next.irq_meta_n = irq_pin_n_i;
    state_next.irq_sync_n = state_reg.irq_meta_n;

    state_next.load.load      = 1'b0;
    state_next.load.mask_load = 1'b0;

    // Instruction boundary, bus idle for address errors only, and never between a branch and its slot.
    accept_ok = (state_reg.state == ST_IDLE) && cpu_i.ready && !cpu_i.delay_slot;
    aerr_go   = accept_ok && state_reg.aerr_pend && cpu_i.bus_idle;
    int_go    = accept_ok && !state_reg.aerr_pend && win_valid && !cpu_i.int_block;

    // APB slave: zero wait states, errors on unmapped or misaligned offsets.
    state_next.rsp.pready  = 1'b1;
    state_next.rsp.pslverr = 1'b0;
    if (apb_i.psel && !apb_i.penable) begin
      state_next.rsp.prdata  = rd_err ? 32'h0000_0000 : rd_data;
      state_next.rsp.pslverr = rd_err;
    end
    if (apb_acc && apb_i.pwrite && !rd_err && (apb_i.paddr <= ADDR_PRIO_E)) begin
      state_next.prio[prio_idx] = apb_i.pwdata[15:0];
    end

    case (state_reg.state)
      ST_IDLE: begin
        if (aerr_go) begin
          state_next.aerr_pend = 1'b0;
          state_next.vec       = state_reg.aerr_dma ? VEC_AERR_DMA : VEC_AERR_CPU;
          state_next.state     = ST_PUSH_SR;
        end else if (int_go) begin
          state_next.vec       = win_vec;
          state_next.state     = ST_PUSH_SR;
          if (win_nmi) begin
            state_next.nmi_pend = 1'b0;
          end
          state_next.load.mask_load = 1'b1;
          state_next.load.mask      = win_nmi ? MASK_NMI : win_level[3:0];
        end
        if (aerr_go || int_go) begin
          state_next.saved_sr  = cpu_i.status_word;
          state_next.saved_pc  = cpu_i.next_pc;
          state_next.sp        = cpu_i.sp - STACK_STEP;
          state_next.vbr       = cpu_i.vbr;
          state_next.mem.req   = 1'b1;
          state_next.mem.we    = 1'b1;
          state_next.mem.addr  = cpu_i.sp - STACK_STEP;
          state_next.mem.wdata = cpu_i.status_word;
        end
      end
      ST_PUSH_SR: begin
        if (mem_ack_i) begin
          state_next.sp        = state_reg.sp - STACK_STEP;
          state_next.mem.addr  = state_reg.sp - STACK_STEP;
          state_next.mem.wdata = state_reg.saved_pc;
          state_next.state     = ST_PUSH_PC;
        end
      end
      ST_PUSH_PC: begin
        if (mem_ack_i) begin
          state_next.mem.we    = 1'b0;
          state_next.mem.wdata = 32'h0000_0000;
          state_next.mem.addr  = state_reg.vbr + {22'h000000, state_reg.vec, 2'b00};
          state_next.state     = ST_READ_VEC;
        end
      end
      ST_READ_VEC: begin
        if (mem_ack_i) begin
          state_next.mem.req   = 1'b0;
          state_next.mem.addr  = 32'h0000_0000;
          state_next.load.pc   = mem_rdata_i;
          state_next.load.sp   = state_reg.sp;
          state_next.state     = ST_JUMP;
        end
      end
      ST_JUMP: begin
        // The target is loaded straight into the PC, so no slot follows.
        state_next.load.load = 1'b1;
        state_next.last_vec  = state_reg.vec;
        state_next.state     = ST_IDLE;
      end
      default: begin
        state_next.state = ST_IDLE;
      end
    endcase

    // New events are set last so that they win over a clear in the same cycle.
    if (state_reg.nmi_sync && !state_reg.nmi_prev) begin
      state_next.nmi_pend = 1'b1;
    end
    // Our own stacking accesses are never checked, so entry cannot loop on itself.
    if (aerr_now) begin
      state_next.aerr_pend = 1'b1;
      state_next.aerr_dma  = aerr_now_dma;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg            <= '0;
      state_reg.state      <= ST_IDLE;
      state_reg.irq_meta_n <= '1;
      state_reg.irq_sync_n <= '1;
      state_reg.prio       <= {NUM_PRIO_REGS{PRIO_RESET}};
      state_reg.rsp.pready <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign apb_o      = state_reg.rsp;
  assign mem_o      = state_reg.mem;
  assign cpu_load_o = state_reg.load;
  assign cpu_hold_o = (state_reg.state != ST_IDLE);

endmodule

// *** rtl/exc_pkg.sv ***
// Package with constants and carrier types for the exception entry unit.
package exc_pkg;

  localparam int          NUM_IRQ        = 8;
  localparam int          NUM_DMA_SRC    = 4;
  localparam int          NUM_TMR_SRC    = 15;
  localparam int          NUM_SER_SRC    = 8;
  localparam int          NUM_ADC_SRC    = 1;
  localparam int          NUM_WDT_SRC    = 1;
  localparam int          NUM_BSU_SRC    = 2;
  localparam int          NUM_PERIPH     = NUM_DMA_SRC + NUM_TMR_SRC + NUM_SER_SRC
                                         + NUM_ADC_SRC + NUM_WDT_SRC + NUM_BSU_SRC;
  localparam int          NUM_PRIO_REGS  = 5;
  localparam int          FIELDS_PER_REG = 4;
  localparam int          NUM_FIELDS     = NUM_PRIO_REGS * FIELDS_PER_REG;
  localparam int          FIELD_W        = 4;

  // Source index bases inside the peripheral request vector.
  localparam int          DMA_BASE       = 0;
  localparam int          TMR_BASE       = DMA_BASE + NUM_DMA_SRC;
  localparam int          SER_BASE       = TMR_BASE + NUM_TMR_SRC;
  localparam int          ADC_BASE       = SER_BASE + NUM_SER_SRC;
  localparam int          WDT_BASE       = ADC_BASE + NUM_ADC_SRC;
  localparam int          BSU_BASE       = WDT_BASE + NUM_WDT_SRC;

  // Priority field bases for each group.
  localparam int          FLD_IRQ        = 0;
  localparam int          FLD_DMA        = 8;
  localparam int          FLD_TMR        = 10;
  localparam int          FLD_SER        = 15;
  localparam int          FLD_MISC       = 19;
  localparam int          DMA_PER_FLD    = 2;
  localparam int          TMR_PER_FLD    = 3;
  localparam int          SER_PER_FLD    = 2;

  localparam logic [4:0]  LEVEL_NMI      = 5'h10;
  localparam logic [4:0]  LEVEL_UBRK     = 5'h0f;
  localparam logic [3:0]  MASK_NMI       = 4'hf;

  localparam logic [7:0]  VEC_AERR_CPU   = 8'h09;
  localparam logic [7:0]  VEC_AERR_DMA   = 8'h0a;
  localparam logic [7:0]  VEC_NMI        = 8'h0b;
  localparam logic [7:0]  VEC_UBRK       = 8'h0c;
  localparam logic [7:0]  VEC_IRQ_BASE   = 8'h40;
  localparam logic [7:0]  VEC_PER_BASE   = 8'h48;

  localparam int          MASK_LSB       = 4;
  localparam int          MASK_MSB       = 7;
  localparam logic [31:0] STACK_STEP     = 32'h0000_0004;
  localparam logic [31:0] PERIPH_LO      = 32'h0500_0000;
  localparam logic [31:0] PERIPH_HI      = 32'h05ff_ffff;

  localparam logic [7:0]  ADDR_PRIO_A    = 8'h00;
  localparam logic [7:0]  ADDR_PRIO_E    = 8'h10;
  localparam logic [7:0]  ADDR_STATUS    = 8'h14;
  localparam logic [7:0]  ADDR_PEND      = 8'h18;
  localparam logic [15:0] PRIO_RESET     = 16'h0000;

  typedef enum logic [1:0] {
    SIZE_BYTE,
    SIZE_WORD,
    SIZE_LONG
  } size_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } apb_rsp_type;

  typedef struct packed {
    logic        valid;
    logic        is_fetch;
    logic        is_dma;
    size_type    size;
    logic [31:0] addr;
  } access_type;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_type;

  typedef struct packed {
    logic        ready;
    logic        delay_slot;
    logic        int_block;
    logic        bus_idle;
    logic [31:0] status_word;
    logic [31:0] next_pc;
    logic [31:0] sp;
    logic [31:0] vbr;
  } cpu_view_type;

  typedef struct packed {
    logic        load;
    logic [31:0] pc;
    logic [31:0] sp;
    logic        mask_load;
    logic [3:0]  mask;
  } cpu_load_type;

endpackage

// *** tb/address_error_and_interrupt_accept_sva.sv ***
// Checker for the port timing of the exception entry unit.
`timescale 1ns/1ps
module exc_entry_checker
  import exc_pkg::*;
#(
  parameter logic [31:0] PERIPH_START = PERIPH_LO,
  parameter logic [31:0] PERIPH_END   = PERIPH_HI
) (
  input wire logic         clk_i,
  input wire logic         arst_n_i,
  input wire apb_req_type  apb_i,
  input wire apb_rsp_type  apb_o,
  input wire access_type   access_i,
  input wire cpu_view_type cpu_i,
  input wire cpu_load_type cpu_load_o,
  input wire logic         cpu_hold_o,
  input wire mem_req_type  mem_o,
  input wire logic         mem_ack_i,
  input wire logic [31:0]  mem_rdata_i
);
  logic [31:0] vec_reg;
  logic        free;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  assign free = access_i.valid && !cpu_hold_o && cpu_i.ready && !cpu_i.delay_slot
                && cpu_i.bus_idle;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vec_reg <= 32'h0;
    end else if (mem_ack_i && mem_o.req && !mem_o.we) begin
      vec_reg <= mem_rdata_i;
    end
  end

  a_fetch_odd: assert property (free && access_i.is_fetch && access_i.addr[0]
    |-> ##[1:4] cpu_hold_o) else $error("odd fetch not taken");
  a_fetch_space: assert property (free && access_i.is_fetch
    && access_i.addr >= PERIPH_START && access_i.addr <= PERIPH_END
    |-> ##[1:4] cpu_hold_o) else $error("peripheral fetch not taken");
  a_data_align: assert property (free && !access_i.is_fetch
    && ((access_i.size == SIZE_WORD && access_i.addr[0])
    || (access_i.size == SIZE_LONG && access_i.addr[1:0] != 2'b00))
    |-> ##[1:4] cpu_hold_o) else $error("misaligned data not taken");
  a_slot_block: assert property (cpu_i.delay_slot && !cpu_hold_o |=> !cpu_hold_o)
    else $error("entry during delay slot");
  a_status_push: assert property ($rose(cpu_hold_o) |-> mem_o.req && mem_o.we
    && mem_o.addr == cpu_i.sp - STACK_STEP && mem_o.wdata == cpu_i.status_word)
    else $error("first push wrong");
  a_pc_push: assert property (mem_ack_i && mem_o.req && mem_o.we
    && mem_o.addr == cpu_i.sp - STACK_STEP |-> ##[1:3] (mem_o.req && mem_o.we
    && mem_o.addr == cpu_i.sp - 32'h8 && mem_o.wdata == cpu_i.next_pc))
    else $error("second push wrong");
  a_vec_load: assert property (mem_ack_i && mem_o.req && !mem_o.we
    |-> ##[1:3] (cpu_load_o.load && cpu_load_o.pc == vec_reg
    && cpu_load_o.sp == cpu_i.sp - 32'h8)) else $error("handler load wrong");
  a_mask_above: assert property (cpu_load_o.mask_load
    |-> cpu_load_o.mask > cpu_i.status_word[MASK_MSB:MASK_LSB]
    || cpu_load_o.mask == MASK_NMI) else $error("mask level not above");
  a_mask_pulse: assert property (cpu_load_o.mask_load |=> !cpu_load_o.mask_load)
    else $error("mask load not a pulse");
  a_apb_ready: assert property (apb_i.psel && apb_i.penable |-> apb_o.pready)
    else $error("apb not ready");
  a_apb_refuse: assert property (apb_i.psel && !apb_i.penable && apb_i.paddr[1:0] != 2'b00
    |=> apb_o.pslverr && apb_o.prdata == 32'h0) else $error("unaligned apb accepted");
  a_mem_hold: assert property (mem_o.req && !mem_ack_i |=> mem_o.req && $stable(mem_o.addr))
    else $error("memory request dropped");
endmodule

bind address_error_and_interrupt_accept exc_entry_checker #(
  .PERIPH_START(PERIPH_START),
  .PERIPH_END  (PERIPH_END)
) exc_entry_checker_inst (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .apb_i(apb_i), .apb_o(apb_o), .access_i(access_i),
  .cpu_i(cpu_i), .cpu_load_o(cpu_load_o), .cpu_hold_o(cpu_hold_o), .mem_o(mem_o),
  .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i)
);

// *** tb/mem_responder.sv ***
// Memory model answering the stacking writes and vector reads.
`timescale 1ns/1ps
module mem_responder
  import exc_pkg::*;
#(
  parameter logic [31:0] KEY = 32'h5a5a_0000
) (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire mem_req_type mem_i,
  input  wire logic        slow_i,
  output logic             mem_ack_o,
  output logic [31:0]      mem_rdata_o
);
  logic [1:0] wait_reg;

  // Read data toggles outside an answer so stale data is never taken for a reply.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_reg    <= 2'h0;
      mem_ack_o   <= 1'b0;
      mem_rdata_o <= 32'h0;
    end else begin
      mem_ack_o   <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      if (mem_i.req && !mem_ack_o) begin
        if (slow_i && wait_reg != 2'h3) begin
          wait_reg <= wait_reg + 2'h1;
        end else begin
          wait_reg    <= 2'h0;
          mem_ack_o   <= 1'b1;
          mem_rdata_o <= mem_i.addr ^ KEY;
        end
      end
    end
  end
endmodule

// *** tb/test_address_error_and_interrupt_accept.sv ***
// Self-checking bench for address error detection and interrupt entry.
`timescale 1ns/1ps
module test_address_error_and_interrupt_accept;
  import exc_pkg::*;
  localparam logic [31:0] KEY = 32'h5a5a_0000;
  typedef struct packed {
    logic        fetch;
    logic        dma;
    size_type    size;
    logic [31:0] addr;
    logic        err;
  } row_type;
  logic clk_i, arst_n_i, nmi_pin_i, user_break_i, cpu_hold_o, mem_ack_i, slow;
  logic [7:0]  irq_n;
  logic [30:0] periph;
  logic [31:0] mem_rdata, rd;
  logic        err;
  apb_req_type apb;
  apb_rsp_type apb_o;
  access_type  acc;
  cpu_view_type cpu;
  cpu_load_type cpu_load_o;
  mem_req_type mem_o;
  int          num_errors, n_checks, cycles;
  row_type     rows [12] = '{
    '{1'b1, 1'b0, SIZE_WORD, 32'h0000_1000, 1'b0}, '{1'b1, 1'b0, SIZE_WORD, 32'h0000_1001, 1'b1},
    '{1'b1, 1'b0, SIZE_WORD, 32'h0500_0000, 1'b1}, '{1'b1, 1'b0, SIZE_WORD, 32'h05ff_fffe, 1'b1},
    '{1'b1, 1'b0, SIZE_WORD, 32'h0600_0000, 1'b0}, '{1'b0, 1'b0, SIZE_WORD, 32'h0000_2001, 1'b1},
    '{1'b0, 1'b1, SIZE_WORD, 32'h0000_2003, 1'b1}, '{1'b0, 1'b1, SIZE_WORD, 32'h0000_2002, 1'b0},
    '{1'b0, 1'b0, SIZE_LONG, 32'h0000_2002, 1'b1}, '{1'b0, 1'b1, SIZE_LONG, 32'h0000_2005, 1'b1},
    '{1'b0, 1'b0, SIZE_LONG, 32'h0000_2004, 1'b0}, '{1'b0, 1'b0, SIZE_BYTE, 32'h0000_2001, 1'b0}};

  address_error_and_interrupt_accept address_error_and_interrupt_accept_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .apb_i(apb), .apb_o(apb_o), .nmi_pin_i(nmi_pin_i),
    .irq_pin_n_i(irq_n), .user_break_i(user_break_i), .periph_req_i(periph), .access_i(acc),
    .cpu_i(cpu), .cpu_load_o(cpu_load_o), .cpu_hold_o(cpu_hold_o), .mem_o(mem_o),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata));
  mem_responder #(.KEY(KEY)) mem_responder_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .mem_i(mem_o), .slow_i(slow), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic apb_rw(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    apb <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:wd};
    @(posedge clk_i);
    apb.penable <= 1'b1;
    n = 0;
    do begin @(posedge clk_i); n++; end while (apb_o.pready !== 1'b1 && n < 50);
    rd = apb_o.prdata;
    err = apb_o.pslverr;
    apb <= '0;
  endtask

  // Requests drop and ready falls as soon as entry starts, so a level still in the
  // synchroniser cannot start a second entry behind the first.
  task automatic entry(input logic exp, input logic [7:0] vec, input logic [3:0] mask,
                       input logic has_mask);
    int n;
    logic seen, mseen;
    logic [3:0] got_mask;
    n = 0;
    mseen = 1'b0;
    got_mask = 4'h0;
    while (n < 12 && cpu_hold_o !== 1'b1) begin @(posedge clk_i); n++; end
    seen = (cpu_hold_o === 1'b1);
    chk({31'h0, seen}, {31'h0, exp}, "entry taken");
    cpu.ready <= 1'b0;
    irq_n <= 8'hff;
    user_break_i <= 1'b0;
    periph <= '0;
    nmi_pin_i <= 1'b0;
    n = 0;
    while (seen && n < 100 && cpu_load_o.load !== 1'b1) begin
      if (cpu_load_o.mask_load === 1'b1) begin mseen = 1'b1; got_mask = cpu_load_o.mask; end
      @(posedge clk_i);
      n++;
    end
    if (seen) begin
      chk(cpu_load_o.pc, (cpu.vbr + {22'h0, vec, 2'b00}) ^ KEY, "handler pc");
      chk({31'h0, mseen}, {31'h0, has_mask}, "mask load");
      chk({28'h0, got_mask}, {28'h0, mask}, "mask value");
    end
    repeat (4) @(posedge clk_i);
    cpu.ready <= 1'b1;
    $display("test done vector %h", vec);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  initial begin
    arst_n_i = 1'b0; apb = '0; nmi_pin_i = 1'b0; irq_n = 8'hff; user_break_i = 1'b0;
    periph = '0; acc = '0; slow = 1'b0; num_errors = 0; n_checks = 0; cycles = 0;
    cpu = '{ready:1'b1, delay_slot:1'b0, int_block:1'b0, bus_idle:1'b1,
            status_word:32'h0000_00f0, next_pc:32'h0000_1234, sp:32'h0000_8000,
            vbr:32'h0001_0000};
    repeat (4) @(posedge clk_i);
    chk({31'h0, apb_o.pready}, 32'h1, "reset pready");
    chk({30'h0, mem_o.req, cpu_hold_o}, 32'h0, "reset idle");
    arst_n_i <= 1'b1;
    foreach (rows[i]) begin
      slow <= i[0];
      @(posedge clk_i);
      acc <= '{valid:1'b1, is_fetch:rows[i].fetch, is_dma:rows[i].dma, size:rows[i].size,
               addr:rows[i].addr};
      @(posedge clk_i);
      acc.valid <= 1'b0;
      entry(rows[i].err, rows[i].dma ? VEC_AERR_DMA : VEC_AERR_CPU, 4'h0, 1'b0);
    end
    apb_rw(1'b1, ADDR_PRIO_A, 32'hffff_0035);
    apb_rw(1'b0, ADDR_PRIO_A, 32'h0);
    chk(rd, 32'h0000_0035, "prio readback");
    apb_rw(1'b0, 8'h1c, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    apb_rw(1'b1, 8'h0a, 32'h0);
    chk({31'h0, err}, 32'h1, "unaligned error");
    apb_rw(1'b1, 8'h08, 32'h0000_0007);
    cpu.status_word <= 32'h0000_0040;
    irq_n <= 8'hfd;
    entry(1'b0, VEC_IRQ_BASE, 4'h0, 1'b0);
    irq_n <= 8'hfc;
    entry(1'b1, VEC_IRQ_BASE, 4'h5, 1'b1);
    cpu.status_word <= 32'h0000_0050;
    irq_n <= 8'hfe;
    entry(1'b0, VEC_IRQ_BASE, 4'h0, 1'b0);
    cpu.status_word <= 32'h0000_0060;
    irq_n <= 8'hfe;
    periph <= 31'h1;
    entry(1'b1, VEC_PER_BASE, 4'h7, 1'b1);
    cpu.status_word <= 32'h0000_00e0;
    cpu.delay_slot <= 1'b1;
    user_break_i <= 1'b1;
    entry(1'b0, VEC_UBRK, 4'h0, 1'b0);
    cpu.delay_slot <= 1'b0;
    user_break_i <= 1'b1;
    entry(1'b1, VEC_UBRK, 4'hf, 1'b1);
    cpu.status_word <= 32'h0000_00f0;
    user_break_i <= 1'b1;
    entry(1'b0, VEC_UBRK, 4'h0, 1'b0);
    nmi_pin_i <= 1'b1;
    entry(1'b1, VEC_NMI, MASK_NMI, 1'b1);
    // Interrupt blocking must hold back a break that the mask would let through.
    cpu.status_word <= 32'h0000_00e0;
    cpu.int_block <= 1'b1;
    user_break_i <= 1'b1;
    entry(1'b0, VEC_UBRK, 4'h0, 1'b0);
    // A busy bus defers an address error, which is still taken under interrupt blocking.
    cpu.bus_idle <= 1'b0;
    @(posedge clk_i);
    acc <= '{valid:1'b1, is_fetch:1'b1, is_dma:1'b0, size:SIZE_WORD, addr:32'h0000_3001};
    @(posedge clk_i);
    acc.valid <= 1'b0;
    entry(1'b0, VEC_AERR_CPU, 4'h0, 1'b0);
    cpu.bus_idle <= 1'b1;
    entry(1'b1, VEC_AERR_CPU, 4'h0, 1'b0);
    cpu.int_block <= 1'b0;
    apb_rw(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, {20'h00000, VEC_AERR_CPU, 4'h0}, "last vector");
    apb_rw(1'b0, ADDR_PEND, 32'h0);
    chk(rd, 32'h0000_0000, "nothing pending");
    // Second reset in mid-run must clear the programmed priorities.
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({30'h0, mem_o.req, cpu_hold_o}, 32'h0, "mid reset idle");
    arst_n_i <= 1'b1;
    apb_rw(1'b0, ADDR_PRIO_A, 32'h0);
    chk(rd, 32'h0000_0000, "prio after reset");
    $display("test done reset");
    end_sim();
  end
endmodule
